// ===== hdl/csb_ctrl.sv
module csb_ctrl #(
  parameter logic [7:0] DIV_MIN = csb_pkg::DIV_MIN_STD
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             PRECHARGE_CLK,
  output logic             MOD_CLK,
  output logic             SENSOR_SIG,
  output logic             SHIELD_SIG,
  output logic             INACT_TO_GND,
  output logic             INACT_TO_SHIELD,
  output logic             INACT_HIZ,
  output logic             TANK_PRE_PIN,
  output logic             TANK_EN,
  output logic             SCAN_TICK
);
  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  logic [31:0] ctrl;
  logic [7:0]  sense_div;
  logic [7:0]  mod_div;
  logic [7:0]  noise_th;
  logic [7:0]  neg_noise_th;
  logic [7:0]  low_limit;
  logic [7:0]  slot_div [csb_pkg::SLOTS];
  logic [15:0] raw;
  logic        sample_valid;
  logic [31:0] next_ctrl;
  logic [7:0]  next_sense_div;
  logic [7:0]  next_mod_div;
  logic [7:0]  next_noise_th;
  logic [7:0]  next_neg_noise_th;
  logic [7:0]  next_low_limit;
  logic [7:0]  next_slot_div [csb_pkg::SLOTS];
  logic [15:0] next_raw;
  logic        next_sample_valid;
  logic [31:0] next_rdata;

  logic [15:0] baseline;
  logic [7:0]  low_count;
  logic [1:0]  sh_pipe;
  logic [1:0]  next_sh_pipe;
  logic        sens_q;
  logic        next_sens_q;
  logic        mod_q;
  logic        next_mod_q;
  logic        shield_en;
  logic [1:0]  inact_sel;
  logic [1:0]  delay_sel;
  logic [csb_pkg::SLOT_W-1:0] slot;
  csb_pkg::csb_inact_t inact_mode;
  logic        shield_tap;
  logic        inact_gnd;
  logic        inact_hiz;
  logic        inact_shield;

  csb_clk_if sense_if ();
  csb_clk_if mod_if ();

  assign shield_en = ctrl[csb_pkg::CTRL_SHIELD_BIT];
  assign inact_sel = ctrl[csb_pkg::CTRL_INACT_LSB +: 2];
  assign delay_sel = ctrl[csb_pkg::CTRL_DELAY_LSB +: 2];
  assign slot      = ctrl[csb_pkg::CTRL_SLOT_LSB +: csb_pkg::SLOT_W];

  // Read mux for reported values; 8-bit mode saturates at the byte range.
  function automatic logic [15:0] report(input logic [15:0] v, input logic wide);
    if (wide) begin
      report = v;
    end else begin
      report = (v > 16'h00ff) ? 16'h00ff : v;
    end
  endfunction : report

  // ****************************************************************
  // Register writes.
  // ****************************************************************
  always_comb begin
    next_ctrl         = ctrl;
    next_sense_div    = sense_div;
    next_mod_div      = mod_div;
    next_noise_th     = noise_th;
    next_neg_noise_th = neg_noise_th;
    next_low_limit    = low_limit;
    next_slot_div     = slot_div;
    next_raw          = raw;
    next_sample_valid = 1'b0;
    if (WR) begin
      unique case (ADDR)
        csb_pkg::ADDR_CTRL: begin
          next_ctrl = {16'h0000, WDATA[15:0]};
        end
        csb_pkg::ADDR_DIV: begin
          next_sense_div = WDATA[7:0];
          next_mod_div   = WDATA[15:8];
        end
        csb_pkg::ADDR_BASECFG: begin
          next_noise_th     = WDATA[7:0];
          next_neg_noise_th = WDATA[15:8];
          next_low_limit    = WDATA[23:16];
        end
        csb_pkg::ADDR_SLOTDIV: begin
          next_slot_div[WDATA[8 +: csb_pkg::SLOT_W]] = WDATA[7:0];
        end
        csb_pkg::ADDR_SAMPLE: begin
          next_raw          = WDATA[15:0];
          next_sample_valid = 1'b1;
        end
        default: begin
          next_raw = raw;
        end
      endcase
    end
    // Shield on overrides the idle-sensor choice.
    if (next_ctrl[csb_pkg::CTRL_SHIELD_BIT]) begin
      next_ctrl[csb_pkg::CTRL_INACT_LSB +: 2] = 2'(csb_pkg::CSB_INACT_SHIELD);
    end else if (next_ctrl[csb_pkg::CTRL_INACT_LSB +: 2] == 2'(csb_pkg::CSB_INACT_SHIELD)
                 || next_ctrl[csb_pkg::CTRL_INACT_LSB +: 2] == 2'h3) begin
      next_ctrl[csb_pkg::CTRL_INACT_LSB +: 2] = 2'(csb_pkg::CSB_INACT_GND);
    end
  end

  // Read data: one cycle after the strobe, zero for unmapped addresses.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (RD) begin
      unique case (ADDR)
        csb_pkg::ADDR_CTRL:     next_rdata = ctrl;
        csb_pkg::ADDR_DIV:      next_rdata = {16'h0000, mod_div, sense_div};
        csb_pkg::ADDR_BASECFG:  next_rdata = {8'h00, low_limit, neg_noise_th, noise_th};
        csb_pkg::ADDR_SLOTDIV:  next_rdata = {24'h000000, slot_div[slot]};
        csb_pkg::ADDR_SAMPLE:   next_rdata = {16'h0000, raw};
        csb_pkg::ADDR_STATUS:   next_rdata = {24'h000000, low_count};
        csb_pkg::ADDR_BASELINE: begin
          next_rdata = {16'h0000, report(baseline, ctrl[csb_pkg::CTRL_WIDE_BIT])};
        end
        default:                next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl         <= 32'h0000_0000;
      sense_div    <= csb_pkg::SENSE_DIV_RST;
      mod_div      <= csb_pkg::MOD_DIV_RST;
      noise_th     <= csb_pkg::NOISE_RST;
      neg_noise_th <= csb_pkg::NEG_NOISE_RST;
      low_limit    <= csb_pkg::LOW_RESET_RST;
      for (int i = 0; i < csb_pkg::SLOTS; i++) begin
        slot_div[i] <= csb_pkg::SENSE_DIV_RST;
      end
      raw          <= 16'h0000;
      sample_valid <= 1'b0;
      RDATA        <= 32'h0000_0000;
    end else begin
      ctrl         <= next_ctrl;
      sense_div    <= next_sense_div;
      mod_div      <= next_mod_div;
      noise_th     <= next_noise_th;
      neg_noise_th <= next_neg_noise_th;
      low_limit    <= next_low_limit;
      slot_div     <= next_slot_div;
      raw          <= next_raw;
      sample_valid <= next_sample_valid;
      RDATA        <= next_rdata;
    end
  end

  // ****************************************************************
  // Clock dividers.
  // ****************************************************************
  // Per-slot mode picks the slot's divider; the modulator stays global.
  assign sense_if.div = ctrl[csb_pkg::CTRL_PERSLOT_BIT] ? slot_div[slot] : sense_div;
  assign mod_if.div   = mod_div;

  csb_divider #(.MIN_DIV(DIV_MIN)) u_sense (
    .clk  (REF_CLK),
    .rst  (RST),
    .port (sense_if.gen)
  );

  csb_divider #(.MIN_DIV(DIV_MIN)) u_mod (
    .clk  (REF_CLK),
    .rst  (RST),
    .port (mod_if.gen)
  );

  // Divided clocks toggle per period; the shield tap delays the sensor phase.
  always_comb begin
    next_sens_q  = sens_q ^ sense_if.toggle;
    next_mod_q   = mod_q ^ mod_if.toggle;
    next_sh_pipe = {sh_pipe[0], sens_q};
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sens_q  <= 1'b0;
      mod_q   <= 1'b0;
      sh_pipe <= 2'b00;
    end else begin
      sens_q  <= next_sens_q;
      mod_q   <= next_mod_q;
      sh_pipe <= next_sh_pipe;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  // The precharge clock and the sensor pin phase come from one register, so the
  // shield taps below always line up with what the electrode sees.
  assign PRECHARGE_CLK = sens_q;
  assign MOD_CLK       = mod_q;
  // Scan step rate follows the modulator divider, so a smaller value scans faster.
  assign SCAN_TICK     = mod_if.toggle;
  assign SENSOR_SIG    = sens_q;

  // Delay 0 passes the sensor phase; 1 or 2 take the pipeline taps. 3 acts as 2.
  // The taps are plain flops, so the lag is exact but can never exceed two cycles.
  always_comb begin
    shield_tap = sh_pipe[1];
    unique case (delay_sel)
      2'h0: begin
        shield_tap = sens_q;
      end
      2'h1: begin
        shield_tap = sh_pipe[0];
      end
      2'h2: begin
        shield_tap = sh_pipe[1];
      end
      2'h3: begin
        shield_tap = sh_pipe[1];
      end
    endcase
  end
  // A disabled shield stays low so the tank pin sees no switching.
  assign SHIELD_SIG = shield_en && shield_tap;

  assign inact_mode = csb_pkg::csb_inact_t'(inact_sel);
  // Idle sensor drive; exactly one of the three lines is high at any time.
  // Code 3 never reaches the register, but ground is the quiet fallback for it.
  always_comb begin
    inact_gnd    = 1'b0;
    inact_hiz    = 1'b0;
    inact_shield = 1'b0;
    unique case (inact_mode)
      csb_pkg::CSB_INACT_GND: begin
        inact_gnd = 1'b1;
      end
      csb_pkg::CSB_INACT_HIZ: begin
        inact_hiz = 1'b1;
      end
      csb_pkg::CSB_INACT_SHIELD: begin
        inact_shield = shield_en;
        inact_gnd    = !shield_en;
      end
      default: begin
        inact_gnd = 1'b1;
      end
    endcase
  end

  assign INACT_TO_GND    = inact_gnd;
  assign INACT_HIZ       = inact_hiz;
  assign INACT_TO_SHIELD = inact_shield;
  assign TANK_PRE_PIN    = ctrl[csb_pkg::CTRL_TANKPRE_BIT];
  // Tank enable is software's duty; the pin simply reflects the bit.
  assign TANK_EN         = ctrl[csb_pkg::CTRL_TANKEN_BIT];

  // ****************************************************************
  // Baseline tracking.
  // ****************************************************************
  csb_baseline u_base (
    .clk          (REF_CLK),
    .rst          (RST),
    .sample_valid (sample_valid),
    .raw          (raw),
    .auto_reset   (ctrl[csb_pkg::CTRL_AUTORST_BIT]),
    .noise_th     (noise_th),
    .neg_noise_th (neg_noise_th),
    .low_limit    (low_limit),
    .baseline     (baseline),
    .low_count    (low_count)
  );
endmodule : csb_ctrl

// ===== pkg/csb_pkg.sv
package csb_pkg;
  // ****************************************************************
  // Register map: byte addresses of word registers.
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_DIV      = 8'h04;
  localparam logic [7:0] ADDR_BASECFG  = 8'h08;
  localparam logic [7:0] ADDR_SLOTDIV  = 8'h0c;
  localparam logic [7:0] ADDR_SAMPLE   = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_BASELINE = 8'h18;

  // ****************************************************************
  // Field positions in the control register.
  // ****************************************************************
  localparam int CTRL_PERSLOT_BIT   = 0;
  localparam int CTRL_AUTORST_BIT   = 1;
  localparam int CTRL_WIDE_BIT      = 2;
  localparam int CTRL_SHIELD_BIT    = 3;
  localparam int CTRL_INACT_LSB     = 4;
  localparam int CTRL_DELAY_LSB     = 6;
  localparam int CTRL_TANKPRE_BIT   = 8;
  localparam int CTRL_TANKEN_BIT    = 9;
  localparam int CTRL_CMODPRE_BIT   = 10;
  localparam int CTRL_SLOT_LSB      = 12;

  // ****************************************************************
  // Reset values, divider and threshold floors, and slot sizing.
  // ****************************************************************
  localparam logic [7:0] SENSE_DIV_RST   = 8'h0c;
  localparam logic [7:0] MOD_DIV_RST     = 8'h0c;
  localparam logic [7:0] NEG_NOISE_RST   = 8'h14;
  localparam logic [7:0] NOISE_RST       = 8'h14;
  localparam logic [7:0] LOW_RESET_RST   = 8'h05;
  localparam logic [7:0] DIV_MIN_STD     = 8'h02;
  localparam logic [7:0] DIV_MIN_SMALL   = 8'h01;
  localparam logic [7:0] NEG_NOISE_MIN   = 8'h05;
  localparam logic [7:0] LOW_RESET_MIN   = 8'h01;
  localparam int         SLOTS           = 4;
  localparam int         SLOT_W          = 2;

  // ****************************************************************
  // Enumerations.
  // ****************************************************************
  typedef enum logic [1:0] {
    CSB_INACT_GND,
    CSB_INACT_HIZ,
    CSB_INACT_SHIELD
  } csb_inact_t;
endpackage : csb_pkg

// ===== pkg/csb_clk_if.sv
interface csb_clk_if;
  logic [7:0] div;
  logic       toggle;
  modport ctrl (output div, input  toggle);
  modport gen  (input  div, output toggle);
endinterface : csb_clk_if

// ===== hdl/csb_divider.sv
module csb_divider #(
  parameter logic [7:0] MIN_DIV = 8'h02
) (
  input  wire logic clk,
  input  wire logic rst,
  csb_clk_if.gen    port
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       out;
  logic       next_out;
  logic [7:0] div_eff;

  // Clamp to the legal floor so an illegal write cannot stop the clock.
  assign div_eff = (port.div < MIN_DIV) ? MIN_DIV : port.div;

  // Counts source cycles; output toggles once per divider period.
  always_comb begin
    next_cnt = cnt + 8'h01;
    next_out = 1'b0;
    if (cnt >= div_eff - 8'h01) begin
      next_cnt = 8'h00;
      next_out = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 8'h00;
      out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      out <= next_out;
    end
  end

  assign port.toggle = out;
endmodule : csb_divider

// ===== hdl/csb_baseline.sv
module csb_baseline (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sample_valid,
  input  wire logic [15:0] raw,
  input  wire logic        auto_reset,
  input  wire logic [7:0]  noise_th,
  input  wire logic [7:0]  neg_noise_th,
  input  wire logic [7:0]  low_limit,
  output logic      [15:0] baseline,
  output logic      [7:0]  low_count
);
  logic [15:0] next_baseline;
  logic [7:0]  next_low_count;
  logic [16:0] diff;
  logic        below;
  logic        in_band;
  logic        deep_low;
  logic [7:0]  neg_eff;
  logic [7:0]  lim_eff;

  assign neg_eff  = (neg_noise_th < csb_pkg::NEG_NOISE_MIN) ? csb_pkg::NEG_NOISE_MIN
                                                             : neg_noise_th;
  assign lim_eff  = (low_limit < csb_pkg::LOW_RESET_MIN) ? csb_pkg::LOW_RESET_MIN : low_limit;
  assign below    = raw < baseline;
  assign diff     = below ? {1'b0, baseline - raw} : {1'b0, raw - baseline};
  assign in_band  = diff <= {9'h000, noise_th};
  assign deep_low = below && (diff > {9'h000, neg_eff});

  // Baseline follows raw per auto-reset mode; deep dips wait for the low counter.
  always_comb begin
    next_baseline  = baseline;
    next_low_count = low_count;
    if (sample_valid) begin
      if (!below) begin
        next_low_count = 8'h00;
      end else begin
        next_low_count = low_count + 8'h01;
      end
      if (below && (low_count + 8'h01 >= lim_eff)) begin
        next_baseline  = raw;
        next_low_count = 8'h00;
      end else if (deep_low) begin
        next_baseline  = baseline;
      end else if (auto_reset || in_band) begin
        next_baseline  = raw;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      baseline  <= 16'h0000;
      low_count <= 8'h00;
    end else begin
      baseline  <= next_baseline;
      low_count <= next_low_count;
    end
  end
endmodule : csb_baseline

// ===== testbench/csb_ctrl_props.sv
module csb_ctrl_props (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        PRECHARGE_CLK,
  input wire logic        MOD_CLK,
  input wire logic        SENSOR_SIG,
  input wire logic        SHIELD_SIG,
  input wire logic        INACT_TO_GND,
  input wire logic        INACT_TO_SHIELD,
  input wire logic        INACT_HIZ,
  input wire logic        TANK_PRE_PIN,
  input wire logic        TANK_EN,
  input wire logic        SCAN_TICK
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Shadow of the control word.
  // ****************************************************************
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [1:0]  stab;
  logic [1:0]  next_stab;
  logic        ok;

  // Outputs may lag a control write, so checks wait until it has settled.
  always_comb begin
    next_ctrl = (WR && ADDR == csb_pkg::ADDR_CTRL) ? WDATA : ctrl;
    next_stab = (WR && ADDR == csb_pkg::ADDR_CTRL) ? 2'h0 : ((stab == 2'h3) ? stab : stab + 2'h1);
  end

  // Shadow registers only.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl <= 32'h0;
      stab <= 2'h0;
    end else begin
      ctrl <= next_ctrl;
      stab <= next_stab;
    end
  end

  assign ok = (stab == 2'h3);

  // ****************************************************************
  // Properties.
  // ****************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  AST_SENSOR_PHASE: assert property (SENSOR_SIG == PRECHARGE_CLK)
    else $error("sensor signal differs from precharge clock");
  AST_SHIELD_OFF: assert property (ok && !ctrl[3] |-> !SHIELD_SIG && !INACT_TO_SHIELD)
    else $error("shield activity while shield is off");
  AST_SHIELD_LAG: assert property (ok && ctrl[3] && ctrl[7:6] != 2'h3 |-> SHIELD_SIG ==
    ((ctrl[7:6] == 2'h0) ? SENSOR_SIG : (ctrl[7:6] == 2'h1) ? $past(SENSOR_SIG) :
    $past(SENSOR_SIG, 2)))
    else $error("shield lag wrong");
  AST_SHIELD_FORCE: assert property (ok && ctrl[3] |-> INACT_TO_SHIELD && !INACT_TO_GND
    && !INACT_HIZ)
    else $error("shield does not force idle sensors");
  AST_INACT_DECODE: assert property (ok && !ctrl[3] |-> INACT_HIZ == (ctrl[5:4] == 2'h1)
    && INACT_TO_GND == (ctrl[5:4] != 2'h1))
    else $error("idle sensor drive decode wrong");
  AST_TANK: assert property (ok |-> TANK_PRE_PIN == ctrl[8] && TANK_EN == ctrl[9])
    else $error("tank settings wrong");
  AST_RDATA_IDLE: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data outside read cycle");
  AST_UNMAPPED: assert property (RD && ADDR > csb_pkg::ADDR_BASELINE |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
endmodule : csb_ctrl_props

// ===== testbench/csb_edge_meter.sv
module csb_edge_meter (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sig,
  output int        per
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev;
  int   cnt;

  // Cycles between rising edges, as a sensor pad sees its switching rate.
  always_ff @(posedge clk) begin
    prev <= sig;
    if (rst) begin
      cnt <= 0;
      per <= 0;
    end else if (sig && !prev) begin
      per <= cnt + 1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : csb_edge_meter

// ===== testbench/csb_ctrl_test.sv
module csb_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata, q, cw;
  logic        pre_clk, mod_clk, sensor_sig, shield_sig, to_gnd, to_sh, hiz;
  logic        tank_pre, tank_en, tick;
  int          pre_per, mod_per, tick_per, b, lc;
  int          miscompares = 0;
  int          n_compared = 0;
  int          seed = 32'h3f1d;
  bit          auto_rst, wide;
  logic [7:0]  sens [4] = '{8'h02, 8'h0c, 8'hff, 8'h01};
  logic [7:0]  mods [4] = '{8'h04, 8'h18, 8'hff, 8'h02};
  localparam int NOISE = 10;
  localparam int NEG = 20;
  localparam int LIM = 3;

  csb_ctrl dut (.REF_CLK(ref_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PRECHARGE_CLK(pre_clk), .MOD_CLK(mod_clk), .SENSOR_SIG(sensor_sig),
    .SHIELD_SIG(shield_sig), .INACT_TO_GND(to_gnd), .INACT_TO_SHIELD(to_sh), .INACT_HIZ(hiz),
    .TANK_PRE_PIN(tank_pre), .TANK_EN(tank_en), .SCAN_TICK(tick));
  csb_edge_meter u_pre (.clk(ref_clk), .rst(rst), .sig(pre_clk), .per(pre_per));
  csb_edge_meter u_mod (.clk(ref_clk), .rst(rst), .sig(mod_clk), .per(mod_per));
  csb_edge_meter u_tick (.clk(ref_clk), .rst(rst), .sig(tick), .per(tick_per));

  // Free-running 200 MHz clock.
  always #2.5 ref_clk = ~ref_clk;

  // ****************************************************************
  // Bus, compare and model tasks.
  // ****************************************************************
  // One idle cycle between accesses keeps every strobe assigned once per step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge ref_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask : bus

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask : cmp_reg

  task automatic cmp_per(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask : cmp_per

  function automatic int eff(input logic [7:0] v);
    return (v < 8'h02) ? 2 : int'(v);
  endfunction : eff

  // The longest half period is 255 cycles, so 1100 cycles cover two full periods.
  task automatic measure(input logic [7:0] s, input logic [7:0] m);
    repeat (1100) @(posedge ref_clk);
    #1;
    cmp_per(pre_per, 2 * eff(s));
    cmp_per(mod_per, 2 * eff(m));
    cmp_per(tick_per, eff(m));
  endtask : measure

  task automatic sample(input int raw);
    bus(1'b1, csb_pkg::ADDR_SAMPLE, 32'(raw));
    if (raw < b) begin
      if (lc + 1 >= LIM) begin
        b = raw;
        lc = 0;
      end else begin
        lc++;
        if (b - raw <= NEG && (auto_rst || b - raw <= NOISE)) b = raw;
      end
    end else begin
      lc = 0;
      if (auto_rst || raw - b <= NOISE) b = raw;
    end
    bus(1'b0, csb_pkg::ADDR_BASELINE, 32'h0);
    cmp_reg(q, (wide || b < 256) ? 32'(b) : 32'hff);
    bus(1'b0, csb_pkg::ADDR_STATUS, 32'h0);
    cmp_reg(q, 32'(lc));
  endtask : sample

  task automatic print_verdict();
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // Hang guard.
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    print_verdict();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, csb_pkg::ADDR_DIV, 32'h0);
    cmp_reg(q, 32'h0c0c);
    bus(1'b0, csb_pkg::ADDR_BASECFG, 32'h0);
    cmp_reg(q, 32'h051414);
    bus(1'b1, 8'h40, 32'hffff_ffff);
    bus(1'b0, 8'h40, 32'h0);
    cmp_reg(q, 32'h0);
    measure(8'h0c, 8'h0c);
    // Divider values at both ends of the range, and one below it for the sensor divider.
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, csb_pkg::ADDR_DIV, {16'h0, mods[i], sens[i]});
      measure(sens[i], mods[i]);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, csb_pkg::ADDR_SLOTDIV, {22'h0, 2'(i), 8'(3 + 5 * i)});
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, csb_pkg::ADDR_CTRL, 32'h1 | (i << 12));
      bus(1'b0, csb_pkg::ADDR_SLOTDIV, 32'h0);
      cmp_reg(q, 32'(3 + 5 * i));
      measure(8'(3 + 5 * i), 8'h02);
    end
    bus(1'b1, csb_pkg::ADDR_CTRL, 32'h0);
    measure(8'h02, 8'h02);
    // Every idle drive and shield lag; tank settings except precharge on with enable off.
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 4; m++) begin
        for (int d = 0; d < 3; d++) begin
          cw = (s << 3) | (m << 4) | (d << 6) | (m[0] << 8) | ((m[0] | d[0]) << 9) |
            (d[0] << 10);
          bus(1'b1, csb_pkg::ADDR_CTRL, cw);
          repeat (8) @(posedge ref_clk);
          cmp_reg({29'h0, to_gnd, hiz, to_sh}, s ? 32'h1 : (m == 1 ? 32'h2 : 32'h4));
          cmp_reg({30'h0, tank_pre, tank_en}, {30'h0, m[0], m[0] | d[0]});
          // The stored idle-drive field reads shield with the shield on, and ground for codes 2 and 3 with it off.
          bus(1'b0, csb_pkg::ADDR_CTRL, 32'h0);
          cw[5:4] = s ? 2'h2 : (m == 1 ? 2'h1 : 2'h0);
          cmp_reg(q, cw);
        end
      end
    end
    // Baseline tracking with random raw counts around two levels.
    bus(1'b1, csb_pkg::ADDR_BASECFG, {8'h0, 8'(LIM), 8'(NEG), 8'(NOISE)});
    wide = 1'b1;
    auto_rst = 1'b1;
    b = 0;
    lc = 0;
    bus(1'b1, csb_pkg::ADDR_CTRL, 32'h6);
    for (int k = 0; k < 120; k++) begin
      if (k == 30) begin
        auto_rst = 1'b0;
        bus(1'b1, csb_pkg::ADDR_CTRL, 32'h4);
      end
      if (k == 80) begin
        auto_rst = 1'b1;
        wide = 1'b0;
        bus(1'b1, csb_pkg::ADDR_CTRL, 32'h2);
      end
      sample(k < 80 ? 300 + $random(seed) % 40 : 250 + $random(seed) % 30);
    end
    print_verdict();
  end
endmodule : csb_ctrl_test

bind csb_ctrl csb_ctrl_props u_props (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .PRECHARGE_CLK(PRECHARGE_CLK), .MOD_CLK(MOD_CLK),
  .SENSOR_SIG(SENSOR_SIG), .SHIELD_SIG(SHIELD_SIG), .INACT_TO_GND(INACT_TO_GND),
  .INACT_TO_SHIELD(INACT_TO_SHIELD), .INACT_HIZ(INACT_HIZ), .TANK_PRE_PIN(TANK_PRE_PIN),
  .TANK_EN(TANK_EN), .SCAN_TICK(SCAN_TICK));
